// ===== common/asc_pkg.sv
// Package with timing constants and pin widths for the asynchronous memory controller
package asc_pkg;
	// Memory organisation
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	// Clock rate
	localparam int CLK_PERIOD_NS = 100;
	// Memory timing in ns
	localparam int READ_CYCLE_MIN_NS    = 45;
	localparam int WRITE_CYCLE_MIN_NS   = 45;
	localparam int ADDR_TO_VALID_MAX_NS = 45;
	localparam int OE_TO_VALID_MAX_NS   = 22;
	localparam int WDATA_SETUP_MIN_NS   = 25;
	localparam int ADDR_SETUP_END_NS    = 35;
	localparam int BYTE_SEL_END_NS      = 35;
	localparam int WE_PULSE_MIN_NS      = 35;
	localparam int OUT_RELEASE_MAX_NS   = 18;
	// Derived cycle counts, least times rounded up, at least one cycle
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int READ_WAIT_CYC  = ns_to_cyc(ADDR_TO_VALID_MAX_NS);
	localparam int READ_CYC       = ns_to_cyc(READ_CYCLE_MIN_NS);
	localparam int WRITE_PULSE_CYC = ns_to_cyc(WE_PULSE_MIN_NS);
	localparam int TURN_CYC       = ns_to_cyc(OUT_RELEASE_MAX_NS);
	localparam int CNT_W          = 4;
	// Reset values of pins
	localparam logic [1:0] BYTE_SEL_IDLE = 2'h3;
endpackage : asc_pkg

// ===== rtl/asc_sync.sv
// Two flip-flop synchroniser for the data pins read back from the memory
`timescale 1ns/10ps
module asc_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule : asc_sync

// ===== rtl/asc_host.sv
// Host controller running read and write cycles on an asynchronous 16-bit memory
// How it works
// RULE1: read data is sampled only after the address-to-valid maximum has passed.
// RULE2: previous data stays valid briefly after address change; host ignores it anyway.
// RULE3: output gate asserted early enough that data is valid before sampling.
// RULE4: write address is held stable through the whole strobe.
// RULE5: address may change right after write end; host waits one cycle anyway.
// RULE6: address is set up a cycle before the write strobe falls.
// RULE7: write data is driven a full cycle before the strobe rises.
// RULE8: write data is released only after the strobe has risen.
// RULE9: selected byte lanes are low across the whole write strobe.
// RULE10: memory writes only while strobe, selects and a byte lane overlap.
// RULE11: the write strobe alone ends every write, so timing refers to it.
// RULE12: memory deselects when a chip select drops or both lanes are high.
// RULE13: byte lanes stay high and still whenever the chip is deselected.
// RULE14: memory may enter retention at once after deselect; host needs no wait.
// RULE15: write strobe stays high in every read cycle.
// RULE16: memory floats its pins while the output gate is high in a write.
// RULE17: host drives data only after the output gate has been high long enough.
// RULE18: each cycle lasts at least the minimum cycle time before a new address.
`timescale 1ns/10ps
module asc_host #(
	parameter int ADDR_W = asc_pkg::ADDR_W,
	parameter int DATA_W = asc_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              NRST,
	// User request
	input  wire logic              REQ_VALID,
	output logic                   REQ_READY,
	input  wire logic              REQ_WRITE,
	input  wire logic [ADDR_W-1:0] REQ_ADDR,
	input  wire logic [DATA_W-1:0] REQ_WDATA,
	input  wire logic [1:0]        REQ_BYTE_EN,
	// User answer
	output logic                   RSP_VALID,
	output logic      [DATA_W-1:0] RSP_RDATA,
	// Memory pins
	output logic      [ADDR_W-1:0] MEM_ADDR,
	output logic                   CHIP_SELECT_N,
	output logic                   CHIP_SELECT_HI,
	output logic                   WRITE_STROBE_N,
	output logic                   OUTPUT_GATE_N,
	output logic                   UPPER_BYTE_SEL_N,
	output logic                   LOWER_BYTE_SEL_N,
	input  wire logic [DATA_W-1:0] MEM_DQ_I,
	output logic      [DATA_W-1:0] MEM_DQ_O,
	output logic      [DATA_W-1:0] MEM_DQ_OE_N
);
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_RWAIT = 6'b000010,
		ST_RSAMP = 6'b000100,
		ST_TURN  = 6'b001000,
		ST_WSTRB = 6'b010000,
		ST_WEND  = 6'b100000
	} asc_state_t;

	localparam logic [asc_pkg::CNT_W-1:0] RD_CNT =
		asc_pkg::CNT_W'(asc_pkg::READ_WAIT_CYC + 2);
	localparam logic [asc_pkg::CNT_W-1:0] WR_CNT =
		asc_pkg::CNT_W'(asc_pkg::WRITE_PULSE_CYC);
	localparam logic [asc_pkg::CNT_W-1:0] TN_CNT =
		asc_pkg::CNT_W'(asc_pkg::TURN_CYC);

	// Elaboration checks: the data pins are fixed at 16 bits, and the counter must hold the read wait
	if (ADDR_W < 1 || DATA_W != 16) begin : g_bad_width
		$error("asc_host: memory is 16 bits wide with a nonzero address");
	end
	if (asc_pkg::READ_WAIT_CYC + 2 >= (1 << asc_pkg::CNT_W)) begin : g_bad_cnt
		$error("asc_host: wait counter too narrow");
	end

	// Take decode shared by the sequencer, latch and control processes; a request with no lane is never taken
	function automatic logic req_taken(input logic valid, input logic [1:0] byte_en);
		return valid && (byte_en != 2'h0);
	endfunction : req_taken

	asc_state_t                  state_reg;
	logic [asc_pkg::CNT_W-1:0]   cnt_reg;
	logic                        wr_reg;
	logic [DATA_W-1:0]           dq_sync;
	logic                        take;

	// Request accepted in this cycle
	assign take = (state_reg == ST_IDLE) && req_taken(REQ_VALID, REQ_BYTE_EN);

	// Pin data passes two flops before anything reads it
	asc_sync #(.WIDTH(DATA_W)) u_sync (
		.clk  (CLK_SYS),
		.rst_n(NRST),
		.din  (MEM_DQ_I),
		.dout (dq_sync)
	);

	// Ready only when idle; handshake may be combinational
	assign REQ_READY = (state_reg == ST_IDLE);

	// Sequencer and wait counter
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
			wr_reg    <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (take) begin
						wr_reg <= REQ_WRITE;
						if (REQ_WRITE) begin
							// Address set up one cycle before strobe falls; see RULE6
							state_reg <= ST_TURN;
							cnt_reg   <= TN_CNT;
						end else begin
							// Wait covers access time plus synchroniser; see RULE1
							state_reg <= ST_RWAIT;
							cnt_reg   <= RD_CNT;
						end
					end
				end
				ST_RWAIT: begin
					if (cnt_reg == 1)
						state_reg <= ST_RSAMP;
					cnt_reg <= cnt_reg - 1'b1;
				end
				ST_RSAMP: begin
					state_reg <= ST_IDLE; // see RULE18
				end
				ST_TURN: begin
					// Output gate already high; memory has released pins; see RULE17
					if (cnt_reg == 1) begin
						state_reg <= ST_WSTRB;
						cnt_reg   <= WR_CNT;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_WSTRB: begin
					if (cnt_reg == 1)
						state_reg <= ST_WEND;
					cnt_reg <= cnt_reg - 1'b1;
				end
				ST_WEND: begin
					state_reg <= ST_IDLE; // see RULE5
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Address, lanes and write data latched once per access; stable all cycle
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			MEM_ADDR         <= '0;
			MEM_DQ_O         <= '0;
			UPPER_BYTE_SEL_N <= asc_pkg::BYTE_SEL_IDLE[1];
			LOWER_BYTE_SEL_N <= asc_pkg::BYTE_SEL_IDLE[0];
		end else if (take) begin
			MEM_ADDR         <= REQ_ADDR; // see RULE4
			MEM_DQ_O         <= REQ_WDATA;
			UPPER_BYTE_SEL_N <= ~REQ_BYTE_EN[1]; // see RULE9
			LOWER_BYTE_SEL_N <= ~REQ_BYTE_EN[0];
		end else if (state_reg == ST_RSAMP || state_reg == ST_WEND) begin
			// Lanes park high with the chip deselected; see RULE13
			UPPER_BYTE_SEL_N <= asc_pkg::BYTE_SEL_IDLE[1];
			LOWER_BYTE_SEL_N <= asc_pkg::BYTE_SEL_IDLE[0];
		end
	end

	// Control pins from flops to avoid glitches on the strobes
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			CHIP_SELECT_N  <= 1'b1;
			CHIP_SELECT_HI <= 1'b0;
			WRITE_STROBE_N <= 1'b1;
			OUTPUT_GATE_N  <= 1'b1;
			MEM_DQ_OE_N    <= '1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (take) begin
						// Select opens; gate low only for reads; see RULE3
						CHIP_SELECT_N  <= 1'b0;
						CHIP_SELECT_HI <= 1'b1;
						OUTPUT_GATE_N  <= REQ_WRITE;
					end
					WRITE_STROBE_N <= 1'b1; // see RULE15
				end
				ST_RWAIT: begin
					WRITE_STROBE_N <= 1'b1;
				end
				ST_RSAMP, ST_WEND: begin
					// Deselect; memory may drop to retention at once; see RULE14
					CHIP_SELECT_N  <= 1'b1;
					CHIP_SELECT_HI <= 1'b0;
					OUTPUT_GATE_N  <= 1'b1;
					MEM_DQ_OE_N    <= '1; // see RULE8
				end
				ST_TURN: begin
					if (cnt_reg == 1) begin
						// Data a full strobe ahead of the end; see RULE7
						MEM_DQ_OE_N    <= '0;
						WRITE_STROBE_N <= 1'b0;
					end
				end
				ST_WSTRB: begin
					// Strobe alone terminates; selects outlast it; see RULE11
					if (cnt_reg == 1)
						WRITE_STROBE_N <= 1'b1; // see RULE10
				end
				default: begin
					WRITE_STROBE_N <= 1'b1;
				end
			endcase
		end
	end

	// Answer: read data or write completion, one-cycle pulse
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			RSP_VALID <= 1'b0;
			RSP_RDATA <= '0;
		end else begin
			RSP_VALID <= (state_reg == ST_RSAMP) || (state_reg == ST_WEND);
			if (state_reg == ST_RSAMP && !wr_reg)
				RSP_RDATA <= dq_sync; // see RULE1
		end
	end
endmodule : asc_host

// ===== sim/asc_host_monitor.sv
// Checker of the controller's pin sequencing
`timescale 1ns/10ps
module asc_host_monitor (
	// Clock, reset and user side
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	input wire logic        REQ_VALID,
	input wire logic        REQ_READY,
	input wire logic        REQ_WRITE,
	input wire logic [1:0]  REQ_BYTE_EN,
	input wire logic        RSP_VALID,
	// Memory pins
	input wire logic [19:0] MEM_ADDR,
	input wire logic        CHIP_SELECT_N,
	input wire logic        CHIP_SELECT_HI,
	input wire logic        WRITE_STROBE_N,
	input wire logic        OUTPUT_GATE_N,
	input wire logic        UPPER_BYTE_SEL_N,
	input wire logic        LOWER_BYTE_SEL_N,
	input wire logic [15:0] MEM_DQ_O,
	input wire logic [15:0] MEM_DQ_OE_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	// Taken requests of each kind
	sequence s_rd; REQ_VALID && REQ_READY && !REQ_WRITE && REQ_BYTE_EN != 2'h0; endsequence
	sequence s_wr; REQ_VALID && REQ_READY && REQ_WRITE && REQ_BYTE_EN != 2'h0; endsequence
	// Pin steps that follow a take
	sequence s_rd_steps; (!OUTPUT_GATE_N && WRITE_STROBE_N)[*4] ##1 RSP_VALID; endsequence
	sequence s_wr_steps; WRITE_STROBE_N ##1 !WRITE_STROBE_N ##1 WRITE_STROBE_N ##1 RSP_VALID;
	endsequence
	// Pin relations
	property p_rd; s_rd |=> s_rd_steps; endproperty
	property p_wr; s_wr |=> s_wr_steps; endproperty
	property p_setup; $fell(WRITE_STROBE_N) |-> $stable(MEM_ADDR) && !CHIP_SELECT_N &&
		CHIP_SELECT_HI; endproperty
	property p_pair; CHIP_SELECT_N != CHIP_SELECT_HI; endproperty
	property p_hold; !WRITE_STROBE_N |=> $stable(MEM_ADDR); endproperty
	property p_data; !WRITE_STROBE_N |-> MEM_DQ_OE_N == 16'h0 ##1
		($stable(MEM_DQ_O) && MEM_DQ_OE_N == 16'h0); endproperty
	property p_lanes; !WRITE_STROBE_N |-> !(UPPER_BYTE_SEL_N && LOWER_BYTE_SEL_N); endproperty
	property p_desel; CHIP_SELECT_N |-> UPPER_BYTE_SEL_N && LOWER_BYTE_SEL_N; endproperty
	property p_gate; !OUTPUT_GATE_N |-> MEM_DQ_OE_N == 16'hffff; endproperty
	a_rd: assert property (p_rd) else $error("read sequence wrong");
	a_wr: assert property (p_wr) else $error("write sequence wrong");
	a_setup: assert property (p_setup) else $error("address moved at strobe");
	a_hold: assert property (p_hold) else $error("address moved in write");
	a_data: assert property (p_data) else $error("write data not held");
	a_lanes: assert property (p_lanes) else $error("no lane in write");
	a_desel: assert property (p_desel) else $error("lanes low while idle");
	a_gate: assert property (p_gate) else $error("drive under open gate");
	a_pair: assert property (p_pair) else $error("chip selects disagree");
endmodule : asc_host_monitor
bind asc_host asc_host_monitor u_mon (.*);

// ===== sim/asc_mem_model.sv
// Behavioural model of the static memory behind the controller
`timescale 1ns/10ps
module asc_mem_model (
	// Control pins
	input  wire logic        cs_n,
	input  wire logic        cs_hi,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [1:0]  bs_n,
	// Address and data
	input  wire logic [19:0] addr,
	input  wire logic [15:0] dq_o,
	input  wire logic [15:0] dq_oe_n,
	output logic      [15:0] dq_i
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] drv = 16'h0;
	logic [15:0] w;
	logic        sel;
	// Deselected when a select drops or both lanes are high
	assign sel = !cs_n && cs_hi && !(&bs_n);
	// Wire level from both drivers
	assign dq_i = (dq_o & ~dq_oe_n) | (drv & dq_oe_n);
	// Write lands on the terminating strobe edge, enabled lanes only
	always @(posedge we_n) begin
		w = mem.exists(addr) ? mem[addr] : 16'h0;
		for (int i = 0; i < 16; i++) if (!bs_n[i/8]) w[i] = dq_i[i];
		if (sel) mem[addr] = w;
	end
	// Old data lingers, then a moving pattern so stale values never match
	always @(addr or sel or oe_n or we_n) begin
		drv <= #10 ~drv;
		// Slowest of the address and gate paths, so late sampling is exercised
		if (sel && we_n && !oe_n)
			drv <= #(asc_pkg::ADDR_TO_VALID_MAX_NS) (mem.exists(addr) ? mem[addr] : 16'h0);
	end
endmodule : asc_mem_model

// ===== sim/asc_host_tb.sv
// Self-checking bench for the memory controller
`timescale 1ns/10ps
module asc_host_tb;
	logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic [19:0] req_addr = 20'h0, mem_addr;
	logic [15:0] req_wdata = 16'h0, rsp_rdata, dq_i, dq_o, dq_oe_n;
	logic [1:0] req_be = 2'h0;
	logic req_ready, rsp_valid, cs_n, cs_hi, we_n, oe_n, ub_n, lb_n;
	logic [15:0] exp_mem [logic [19:0]];
	int fails = 0;
	int num_checks = 0;
	asc_host dut (.CLK_SYS(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_BYTE_EN(req_be),
		.RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .MEM_ADDR(mem_addr), .CHIP_SELECT_N(cs_n),
		.CHIP_SELECT_HI(cs_hi), .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n),
		.UPPER_BYTE_SEL_N(ub_n), .LOWER_BYTE_SEL_N(lb_n), .MEM_DQ_I(dq_i), .MEM_DQ_O(dq_o),
		.MEM_DQ_OE_N(dq_oe_n));
	asc_mem_model u_mem (.cs_n(cs_n), .cs_hi(cs_hi), .we_n(we_n), .oe_n(oe_n),
		.bs_n({ub_n, lb_n}), .addr(mem_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
	// Clock
	initial begin
		forever #50 clk = ~clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : check
	// One access; the model keeps the stored word so reads can be predicted
	task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] be);
		logic [15:0] m, old;
		int n;
		m = {{8{be[1]}}, {8{be[0]}}};
		old = exp_mem.exists(a) ? exp_mem[a] : 16'h0;
		req_valid <= 1'b1;
		req_write <= wr;
		req_addr <= a;
		req_wdata <= d;
		req_be <= be;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (req_ready === 1'b1) break;
		end
		req_valid <= 1'b0;
		for (n = 1; n < 9; n++) begin
			@(posedge clk);
			if (rsp_valid === 1'b1) break;
		end
		check("latency", wr ? 16'h4 : 16'h5, 16'(n));
		if (wr) exp_mem[a] = (old & ~m) | (d & m);
		else check("read data", old & m, rsp_rdata & m);
	endtask : access
	// Verdict
	task automatic final_report();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#(3000 * 100);
		fails++;
		final_report();
	end
	// Corner cases, an ignored request, then a random mix on few addresses
	initial begin
		void'($urandom(83607));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		access(1'b1, 20'h0, 16'h1234, 2'h3);
		access(1'b1, 20'hfffff, 16'habcd, 2'h1);
		access(1'b1, 20'hfffff, 16'h5a5a, 2'h2);
		access(1'b0, 20'hfffff, 16'h0, 2'h3);
		access(1'b0, 20'h0, 16'h0, 2'h1);
		req_valid <= 1'b1;
		req_be <= 2'h0;
		repeat (4) @(posedge clk);
		check("select", 16'h1, {15'h0, cs_n});
		req_valid <= 1'b0;
		@(posedge clk);
		repeat (60) access(1'($urandom), {17'h0, 3'($urandom)}, 16'($urandom),
			2'($urandom_range(3, 1)));
		final_report();
	end
endmodule : asc_host_tb
